// ### shared/pfb_pkg.sv
// shared constants and carriers for the process function blocks
package pfb_pkg;
   // values are signed fixed point, 16 fraction bits: 1.0 = 100 %
   localparam int          VAL_W      = 32;
   localparam int          FRAC_W     = 16;
   localparam logic [31:0] ONE        = 32'h0001_0000; // 100 %, logic 1
   localparam logic [31:0] HALF       = 32'h0000_8000; // 0.5 logic threshold
   localparam logic [31:0] ZERO       = 32'h0000_0000;
   localparam logic [31:0] LIMIT_DEF  = 32'h0001_0CCD; // 105 % upper limit preset
   localparam logic [31:0] HYST_DEF   = 32'h0000_0CCD; // 0.050 hysteresis preset
   localparam logic [31:0] BEGIN_MIN  = 32'h0000_0290; // 0.01, first code not below it
   localparam logic [31:0] FINAL_MAX  = 32'h0063_FD70; // 99.99, last code not above it
   localparam int          SQRT_STEPS = 24;            // one result bit per step

   typedef struct packed {
      logic signed [31:0] first_input;
      logic signed [31:0] second_input;
      logic signed [31:0] third_input;
   } triple_t;

   typedef struct packed {
      logic [31:0] pressure_ratio_begin;
      logic [31:0] pressure_ratio_final;
      logic [31:0] heat_ratio_begin;
      logic [31:0] heat_ratio_final;
   } ratio_set_t;

   typedef struct packed {
      logic signed [31:0] picker_out;
      logic signed [31:0] flow_out;
      logic signed [31:0] selector_out;
      logic signed [31:0] switch_out;
      logic signed [31:0] gate_out;
   } results_t;
endpackage

// ### design/process_function_blocks.sv
// process function blocks evaluated once per controller cycle
`timescale 1ns/1ps

// How it works
// RL1: picker gives min of two, limited to third
// RL2: unused third input set above working range
// RL3: first flow input is square-rooted pressure
// RL4: flow output is input times root ratio
// RL5: begin ratios 0.01..1, final 1..99.99
// RL6: negative rooted pressure input treated as zero
// RL7: calculation state within ranges, factor 100
// RL8: celsius limits converted by adding 273.15
// RL9: standard flow uses reference state ratios
// RL10: selector picks second when third >= 0.5
// RL11: switch sets/clears at thresholds, default 0.050
// RL12: gate low only when all inputs high
// RL13: logic inputs are one at 0.5 up
// RL14: logic outputs are 0 % or 100 %
// RL15: unwired essential inputs must be connected
// RL16: switch holds output between thresholds
// RL17: one evaluation per cycle from latched inputs
module process_function_blocks
(
   input  wire logic               ref_clk,
   input  wire logic               sys_rst,
   input  wire logic               cycle_start,
   input  wire pfb_pkg::triple_t   picker_in,
   input  wire pfb_pkg::triple_t   flow_in,
   input  wire pfb_pkg::ratio_set_t ratios,
   input  wire pfb_pkg::triple_t   selector_in,
   input  wire pfb_pkg::triple_t   switch_in,
   input  wire pfb_pkg::triple_t   gate_in,
   output pfb_pkg::results_t       results,
   output logic                    results_valid,
   output logic                    ratio_error
);

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_ROOT = 3'b010,
      ST_DONE = 3'b100
   } state_t;

   state_t                   state_reg;
   pfb_pkg::triple_t         pick_reg, flow_reg, sel_reg, sw_reg, gate_reg;
   pfb_pkg::ratio_set_t      rat_reg;
   logic [23:0]              root_reg;     // root, 16 fraction bits
   logic [47:0]              rem_reg;
   logic [4:0]               step_reg;
   logic                     sw_state_reg;
   pfb_pkg::results_t        res_reg;
   logic                     valid_reg;
   logic                     err_reg;

   // picker: min of first two, then upper limit by third input
   logic signed [31:0]       pick_min;
   logic signed [31:0]       pick_val;
   assign pick_min = (pick_reg.first_input < pick_reg.second_input) ?
                     pick_reg.first_input : pick_reg.second_input; // [RL1]
   assign pick_val = (pick_min > pick_reg.third_input) ?
                     pick_reg.third_input : pick_min;              // [RL1]

   // selector: control input threshold at 0.5
   logic                     sel_ctrl;
   logic signed [31:0]       sel_val;
   assign sel_ctrl = sel_reg.third_input >= $signed(pfb_pkg::HALF); // [RL13]
   assign sel_val  = sel_ctrl ? sel_reg.second_input : sel_reg.first_input; // [RL10]

   // switch thresholds compared at twice the scale, so an odd hysteresis keeps its half bit
   logic signed [33:0]       sw_first2, sw_second2, sw_hyst_x, sw_hyst;
   logic                     sw_set, sw_clr, sw_next;
   assign sw_first2  = {sw_reg.first_input[31], sw_reg.first_input, 1'b0};
   assign sw_second2 = {sw_reg.second_input[31], sw_reg.second_input, 1'b0};
   assign sw_hyst_x  = {{2{sw_reg.third_input[31]}}, sw_reg.third_input};
   assign sw_hyst    = sw_hyst_x[33] ? -sw_hyst_x : sw_hyst_x; // magnitude of third input
   assign sw_set     = sw_first2 >= (sw_second2 + sw_hyst); // [RL11]
   assign sw_clr     = sw_first2 < (sw_second2 - sw_hyst);  // [RL11]
   assign sw_next  = sw_set ? 1'b1 : (sw_clr ? 1'b0 : sw_state_reg);       // [RL16]

   // gate: inputs thresholded at 0.5, low only with all three high
   logic                     gate_val;
   assign gate_val = !((gate_reg.first_input >= $signed(pfb_pkg::HALF)) &&
                       (gate_reg.second_input >= $signed(pfb_pkg::HALF)) &&
                       (gate_reg.third_input >= $signed(pfb_pkg::HALF))); // [RL12] [RL13]

   // ratio parameter range check; out-of-range values are flagged
   logic                     begin_bad, final_bad;
   assign begin_bad = (rat_reg.pressure_ratio_begin < pfb_pkg::BEGIN_MIN) ||
                      (rat_reg.pressure_ratio_begin > pfb_pkg::ONE) ||
                      (rat_reg.heat_ratio_begin < pfb_pkg::BEGIN_MIN) ||
                      (rat_reg.heat_ratio_begin > pfb_pkg::ONE);          // [RL5]
   assign final_bad = (rat_reg.pressure_ratio_final < pfb_pkg::ONE) ||
                      (rat_reg.pressure_ratio_final > pfb_pkg::FINAL_MAX) ||
                      (rat_reg.heat_ratio_final < pfb_pkg::ONE) ||
                      (rat_reg.heat_ratio_final > pfb_pkg::FINAL_MAX);    // [RL5]

   // flow numerator and denominator, negative numerator clamps at zero, denominator at or below zero forced to one LSB
   logic signed [63:0]       num_prod, den_prod;
   logic signed [63:0]       num_full, den_full;
   logic [47:0]              num_pos, den_pos;
   logic [63:0]              quot;
   assign num_prod = $signed({1'b0, rat_reg.pressure_ratio_final - rat_reg.pressure_ratio_begin})
                     * flow_reg.second_input;
   assign den_prod = $signed({1'b0, rat_reg.heat_ratio_final - rat_reg.heat_ratio_begin})
                     * flow_reg.third_input;
   assign num_full = (num_prod >>> 16) + $signed({32'h0, rat_reg.pressure_ratio_begin}); // [RL4]
   assign den_full = (den_prod >>> 16) + $signed({32'h0, rat_reg.heat_ratio_begin});     // [RL4]
   assign num_pos  = num_full[63] ? 48'h0 : num_full[47:0];
   assign den_pos  = (den_full[63] || den_full == 64'sh0) ? 48'h1 : den_full[47:0];
   // ratio kept at 32 fraction bits so its root has 16; wide divide kept single cycle
   assign quot     = 64'({num_pos, 32'h0} / {32'h0, den_pos});

   // bit-serial root, one result bit per cycle to keep the datapath small
   logic [4:0]               bit_pos;
   logic [47:0]              trial;
   logic                     trial_ok;
   assign bit_pos  = 5'(pfb_pkg::SQRT_STEPS) - step_reg; // steps 1..24 resolve bits 23..0
   assign trial    = ((({24'h0, root_reg}) << 2) + 48'h1) << {bit_pos, 1'b0};
   assign trial_ok = rem_reg >= trial;

   // final product, rooted pressure clamped at zero
   logic signed [31:0]       dp_root;
   logic [63:0]              flow_prod;
   assign dp_root   = flow_reg.first_input[31] ? 32'sh0 : flow_reg.first_input; // [RL6]
   assign flow_prod = dp_root * {40'h0, root_reg};

   // sequencer: latch inputs at cycle start, evaluate, publish once
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_reg    <= ST_IDLE;
         pick_reg     <= '0;
         flow_reg     <= '0;
         sel_reg      <= '0;
         sw_reg       <= '0;
         gate_reg     <= '0;
         rat_reg      <= '0;
         root_reg     <= '0;
         rem_reg      <= '0;
         step_reg     <= '0;
         sw_state_reg <= 1'b0;
         res_reg      <= '0;
         valid_reg    <= 1'b0;
         err_reg      <= 1'b0;
      end
      else
      begin
         valid_reg <= 1'b0;
         unique case (state_reg)
            ST_IDLE:
            begin
               if (cycle_start)
               begin
                  pick_reg  <= picker_in;   // [RL17]
                  flow_reg  <= flow_in;     // [RL17]
                  rat_reg   <= ratios;
                  sel_reg   <= selector_in;
                  sw_reg    <= switch_in;
                  gate_reg  <= gate_in;
                  state_reg <= ST_ROOT;
                  step_reg  <= '0;
                  root_reg  <= '0;
               end
            end
            ST_ROOT:
            begin
               if (step_reg == 5'd0)
               begin
                  rem_reg <= quot[47:0];
               end
               else
               begin
                  if (trial_ok)
                  begin
                     rem_reg  <= rem_reg - trial;
                  end
                  root_reg <= {root_reg[22:0], trial_ok};
               end
               if (step_reg == 5'(pfb_pkg::SQRT_STEPS))
                  state_reg <= ST_DONE;
               step_reg <= step_reg + 5'd1;
            end
            ST_DONE:
            begin
               res_reg.picker_out   <= pick_val;
               res_reg.flow_out     <= flow_prod[47:16];                         // [RL4]
               res_reg.selector_out <= sel_val;
               res_reg.switch_out   <= sw_next ? pfb_pkg::ONE : pfb_pkg::ZERO;   // [RL14]
               res_reg.gate_out     <= gate_val ? pfb_pkg::ONE : pfb_pkg::ZERO;  // [RL14]
               sw_state_reg         <= sw_next;                                  // [RL16]
               err_reg              <= begin_bad || final_bad;                   // [RL5]
               valid_reg            <= 1'b1;
               state_reg            <= ST_IDLE;
            end
         endcase
      end
   end

   assign results       = res_reg;
   assign results_valid = valid_reg;
   assign ratio_error   = err_reg;

   chk_switch_set_high: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL11]
      (state_reg == ST_DONE && sw_set) |=> results.switch_out == pfb_pkg::ONE)
      else $error("switch not high above upper threshold");
   chk_switch_hold: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL16]
      (state_reg == ST_DONE && !sw_set && !sw_clr) |=> $stable(results.switch_out))
      else $error("switch changed inside hysteresis band");
   chk_gate_nand: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL12]
      (state_reg == ST_DONE && gate_val == 1'b0) |=> results.gate_out == pfb_pkg::ZERO)
      else $error("gate output wrong");
   chk_picker_limit: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL1]
      (state_reg == ST_DONE) |=> results.picker_out <= $past(pick_reg.third_input))
      else $error("picker above its limit");
   chk_selector_pick: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL10]
      (state_reg == ST_DONE && sel_ctrl) |=> results.selector_out == $past(sel_reg.second_input))
      else $error("selector chose wrong input");
   chk_flow_nonneg: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL6]
      results_valid |-> !results.flow_out[31])
      else $error("flow output negative");
   chk_valid_bound: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL17]
      (state_reg == ST_IDLE && cycle_start) |-> ##27 results_valid)
      else $error("evaluation did not finish on time");
   chk_logic_level: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL14]
      results_valid |-> (results.gate_out == pfb_pkg::ONE || results.gate_out == pfb_pkg::ZERO))
      else $error("logic output not 0 or 100 percent");

endmodule // process_function_blocks

// ### verification/ratio_config.sv
// configuration side model: ratio parameters from transmitter ranges
`timescale 1ns/1ps
module ratio_config
#(
   parameter real P_LO  = 1.0,  // absolute pressure range, bar
   parameter real P_HI  = 5.0,
   parameter real P_CAL = 2.0,  // calculation state, inside range, within factor 100
   parameter real T_LO  = 0.0,  // temperature range, degC
   parameter real T_HI  = 100.0,
   parameter real T_CAL = 20.0
)
(
   input  wire logic           break_begin,
   output pfb_pkg::ratio_set_t ratios
);
   // celsius limits go to kelvin first, else the heat ratios are badly off
   localparam real K_CAL = T_CAL + 273.15;
   // pressure feeds the second input, temperature the third
   assign ratios.pressure_ratio_begin = break_begin ? pfb_pkg::ZERO
                                        : 32'($rtoi(P_LO / P_CAL * 65536.0));
   assign ratios.pressure_ratio_final = 32'($rtoi(P_HI / P_CAL * 65536.0));
   assign ratios.heat_ratio_begin     = 32'($rtoi((T_LO + 273.15) / K_CAL * 65536.0));
   assign ratios.heat_ratio_final     = 32'($rtoi((T_HI + 273.15) / K_CAL * 65536.0));
endmodule // ratio_config

// ### verification/process_function_blocks_tb.sv
// self-checking bench for the process function blocks
`timescale 1ns/1ps
module process_function_blocks_tb;
   logic                ref_clk, sys_rst, cycle_start, bad;
   pfb_pkg::triple_t    pk, fl, se, sw, gt;
   pfb_pkg::ratio_set_t ratios;
   pfb_pkg::results_t   res_out, me;
   logic                results_valid, ratio_error, me_err;
   pfb_pkg::results_t   exp_q[$];
   logic                err_q[$];
   int                  fails = 0, num_checks = 0, nvalid = 0, nrun = 0, fdiff;
   logic [31:0]         seed = 32'h0000_003C;
   logic                sw_state = 1'b0;
   process_function_blocks process_function_blocks_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .cycle_start(cycle_start), .picker_in(pk), .flow_in(fl), .ratios(ratios),
      .selector_in(se), .switch_in(sw), .gate_in(gt), .results(res_out),
      .results_valid(results_valid), .ratio_error(ratio_error));
   ratio_config ratio_config_inst (.break_begin(bad), .ratios(ratios));
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return {14'h0, seed[17:0]} - 32'h0000_8000;
   endfunction
   function automatic logic lg(input logic [31:0] v);
      return $signed(v) >= $signed(pfb_pkg::HALF);
   endfunction
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // one evaluation: note the expectation, pulse start, optionally poke start while busy
   task automatic run(input pfb_pkg::triple_t p, f, s, w, g, input logic extra);
      pfb_pkg::results_t e;
      real               pa, pe, ta, te, fv;
      longint            a, b, h;
      int                n;
      pa = ratios.pressure_ratio_begin / 65536.0;
      pe = ratios.pressure_ratio_final / 65536.0;
      ta = ratios.heat_ratio_begin / 65536.0;
      te = ratios.heat_ratio_final / 65536.0;
      e.picker_out = $signed(p.first_input) < $signed(p.second_input)
                     ? p.first_input : p.second_input;
      if ($signed(p.third_input) < $signed(e.picker_out)) e.picker_out = p.third_input;
      fv = $signed(f.first_input) < 0 ? 0.0 : $itor($signed(f.first_input));
      fv = fv * $sqrt(((pe - pa) * f.second_input / 65536.0 + pa)
                    / ((te - ta) * f.third_input / 65536.0 + ta));
      e.flow_out = $rtoi(fv);
      e.selector_out = lg(s.third_input) ? s.second_input : s.first_input;
      a = 2 * longint'($signed(w.first_input));
      b = 2 * longint'($signed(w.second_input));
      h = $signed(w.third_input) < 0 ? -longint'($signed(w.third_input)) : w.third_input;
      if (a >= b + h) sw_state = 1'b1;
      else if (a < b - h) sw_state = 1'b0;
      e.switch_out = sw_state ? pfb_pkg::ONE : pfb_pkg::ZERO;
      e.gate_out = (lg(g.first_input) && lg(g.second_input) && lg(g.third_input))
                   ? pfb_pkg::ZERO : pfb_pkg::ONE;
      exp_q.push_back(e);
      err_q.push_back(pa < 0.01 || pa > 1.0 || pe < 1.0 || pe > 99.99
                      || ta < 0.01 || ta > 1.0 || te < 1.0 || te > 99.99);
      nrun++;
      @(negedge ref_clk);
      {pk, fl, se, sw, gt} <= {p, f, s, w, g};
      cycle_start <= 1'b1;
      n = 0;
      @(negedge ref_clk);
      cycle_start <= 1'b0;
      while (!results_valid && n < 60)
      begin
         @(negedge ref_clk);
         n++;
         cycle_start <= extra && n == 5;
      end
      check("latency", n, 26);
      if (n >= 60) results();
   endtask
   // watcher: each valid result retires the oldest note
   always @(posedge ref_clk)
      if (results_valid)
      begin
         nvalid++;
         me = exp_q.pop_front();
         me_err = err_q.pop_front();
         check("picker", res_out.picker_out, me.picker_out);
         // root and divide truncate, so the flow is held to a window both ways
         fdiff = res_out.flow_out - me.flow_out;
         check("flow", 32'(fdiff > -256 && fdiff < 256), 1);
         check("selector", res_out.selector_out, me.selector_out);
         check("switch", res_out.switch_out, me.switch_out);
         check("gate", res_out.gate_out, me.gate_out);
         check("ratio_error", 32'(ratio_error), 32'(me_err));
      end
   logic [31:0] sf[8] = '{32'h0000_8667, 32'h0000_8000, 32'h0000_7999, 32'h0000_8000,
                          32'h0000_8666, 32'h0000_799A, 32'h0000_8667, 32'h0000_7999};
   initial
   begin
      {cycle_start, bad, pk, fl, se, sw, gt} = '0;
      sys_rst = 1'b1;
      repeat (16) @(negedge ref_clk);
      sys_rst = 1'b0;
      check("valid idle", 32'(results_valid), 0);
      // boundary table: gate truth table, 0.5 threshold, hysteresis edges, busy poke
      for (int i = 0; i < 8; i++)
         run('{32'(i * 32'h2000), 32'h0000_6000, pfb_pkg::LIMIT_DEF},
             '{32'(i * 32'h4000) - 32'h0000_8000, 32'(i * 32'h2000), 32'h0000_8000},
             '{32'h0000_1111, 32'h0000_2222, i[0] ? pfb_pkg::HALF : pfb_pkg::HALF - 1},
             '{sf[i], pfb_pkg::HALF, pfb_pkg::HYST_DEF},
             '{i[0] ? pfb_pkg::HALF : pfb_pkg::HALF - 1, i[1] ? pfb_pkg::ONE : pfb_pkg::ZERO,
               i[2] ? pfb_pkg::ONE : pfb_pkg::ZERO}, i == 3);
      for (int i = 0; i < 40; i++)
         run('{rnd(), rnd(), rnd()}, '{rnd(), rnd() & 32'hFFFF, rnd() & 32'hFFFF},
             '{rnd(), rnd(), rnd()}, '{rnd(), rnd(), rnd()}, '{rnd(), rnd(), rnd()}, 1'b0);
      // let the broken ratio settle before the expectation reads it
      @(negedge ref_clk);
      bad <= 1'b1;
      @(posedge ref_clk);
      run('{0, 0, 0}, '{pfb_pkg::ONE, pfb_pkg::HALF, pfb_pkg::HALF}, '{0, 0, 0},
          '{0, 0, pfb_pkg::HYST_DEF}, '{0, 0, 0}, 1'b0);
      repeat (2) @(negedge ref_clk);
      check("result count", nvalid, nrun);
      results();
   end
endmodule // process_function_blocks_tb
